// ---- osc_trim_divided_clock_out_reset_kinds.sv ----
// Clock source select, RC trim, divided clock out and reset-kind tracking
`timescale 1ns/1ps
`include "osc_trim_regs.svh"

module osc_trim_divided_clock_out_reset_kinds #(
  parameter int HOLD_CYCLES = `RESET_HOLD_CYCLES,
  parameter int FILTER_CYCLES = `PIN_FILTER_CYCLES,
  parameter int RETAIN_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] osc_select,
  input wire logic osc_in_pin,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  input wire logic external_reset_pin_n,
  output logic external_reset_pin_o,
  output logic external_reset_pin_oe,
  input wire logic trim_wr_en,
  input wire logic [7:0] trim_wr_data,
  output logic [7:0] trim_rd_data,
  input wire logic retained_wr_en,
  input wire logic [RETAIN_W-1:0] retained_wr_data,
  output logic [RETAIN_W-1:0] retained_rd_data,
  input wire logic watchdog_timer_expire,
  input wire logic sleep_enter,
  input wire logic clear_watchdog,
  input wire logic interrupt_wake,
  output logic osc_tick,
  output osc_trim_pkg::osc_mode_e osc_mode,
  output logic config_invalid,
  output logic core_reset,
  output logic wake_pulse,
  output osc_trim_pkg::reset_kind_e reset_kind,
  output logic watchdog_expired_flag,
  output logic sleep_flag
);
  import osc_trim_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES);
  localparam logic [1:0] DIV_LAST = 2'(`DIVIDED_CLOCK_OUT_DIVIDE - 1);

  // Configuration strap, taken once after reset release
  logic [2:0] sel_q;
  logic cfg_loaded_q;
  osc_mode_e mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= `SEL_RESET;
      cfg_loaded_q <= 1'b0;
    end else if (!cfg_loaded_q) begin
      sel_q <= osc_select;
      cfg_loaded_q <= 1'b1;
    end
  end

  // Mode decode shared by the source mux and the pin driver
  assign mode = decode_mode(sel_q);
  assign osc_mode = mode;
  assign config_invalid = (mode == mode_invalid);

  // Filtered reset pin
  logic pin_reset;
  reset_pin_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_pin_filter (
    .clk(clk),
    .rst_n(rst_n),
    .pin_n(external_reset_pin_n),
    .asserted(pin_reset)
  );

  // Watchdog resets never drive the pin; it is input only here
  assign external_reset_pin_o = 1'b0;
  assign external_reset_pin_oe = 1'b0;

  // Sampler for the oscillator input pin, crystal or external clock
  logic oi1_q, oi2_q, oi3_q, oi_level_q, oi_prev_q;
  logic ext_tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oi1_q <= 1'b0;
      oi2_q <= 1'b0;
      oi3_q <= 1'b0;
      oi_level_q <= 1'b0;
      oi_prev_q <= 1'b0;
    end else begin
      oi1_q <= osc_in_pin;
      oi2_q <= oi1_q;
      oi3_q <= oi2_q;
      if (oi2_q == oi3_q) oi_level_q <= oi3_q;
      oi_prev_q <= oi_level_q;
    end
  end

  // One source period per rising edge seen on the pin
  assign ext_tick = oi_level_q && !oi_prev_q;

  // Trim register; unimplemented low bits are never stored
  logic [7:0] trim_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= `TRIM_RESET;
    end else if (core_reset) begin
      trim_q <= `TRIM_RESET;
    end else if (trim_wr_en) begin
      trim_q <= trim_wr_data & `TRIM_IMPL_MASK;
    end
  end
  assign trim_rd_data = trim_q;

  // Trim fields feeding the internal oscillator model
  logic [3:0] fine;
  logic coarse_speedup;
  logic coarse_slowdown;
  logic [15:0] fine_part;
  logic [15:0] up_part;
  logic [15:0] down_part;
  logic [15:0] nco_inc;
  assign fine = trim_q[`TRIM_FINE_MSB:`TRIM_FINE_LSB];
  assign coarse_speedup = trim_q[`TRIM_FAST_BIT];
  assign coarse_slowdown = trim_q[`TRIM_SLOW_BIT];
  assign fine_part = 16'(16'(fine) * `NCO_FINE_STEP);
  assign up_part = coarse_speedup ? `NCO_COARSE_STEP : 16'h0000;
  assign down_part = coarse_slowdown ? `NCO_COARSE_STEP : 16'h0000;
  // Base leaves room for the coarse step down, so no underflow
  assign nco_inc = 16'(`NCO_BASE + fine_part + up_part - down_part);

  // Phase accumulator; carry is one internal oscillator period
  logic [15:0] nco_q;
  logic [16:0] nco_sum;
  logic int_tick;
  assign nco_sum = {1'b0, nco_q} + {1'b0, nco_inc};
  assign int_tick = nco_sum[16];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nco_q <= 16'h0000;
    end else begin
      nco_q <= nco_sum[15:0];
    end
  end

  // Source select; an invalid code gives no clock at all
  logic src_tick;
  assign src_tick = is_internal(mode) ? int_tick :
                    (config_invalid ? 1'b0 : ext_tick);
  assign osc_tick = src_tick;

  // Divide by four; pin shows the top bit of the divider
  logic [1:0] div_q;
  logic out_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
    end else if (src_tick) begin
      div_q <= (div_q == DIV_LAST) ? 2'h0 : div_q + 2'h1;
    end
  end

  // Pin is held low while the reset pin is asserted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= pin_reset ? 1'b0 : div_q[1];
    end
  end

  // Other modes leave the pin to the crystal or the port logic
  assign osc_out_pin_oe = has_divided_clock_out(mode);
  assign osc_out_pin_o = osc_out_pin_oe & out_q;

  // Reset-kind sequencer state
  seq_state_e state_q, state_d;
  logic [HW-1:0] hold_q, hold_d;
  reset_kind_e kind_q, kind_d;
  logic expired_q, expired_d;
  logic asleep_q, asleep_d;
  logic wake_q, wake_d;

  // Pin reset outranks the watchdog, which outranks core requests
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    kind_d = kind_q;
    expired_d = expired_q;
    asleep_d = asleep_q;
    wake_d = 1'b0;
    unique case (state_q)
      seq_hold: begin
        if (pin_reset) begin
          hold_d = HOLD_LOAD;
        end else if (hold_q != '0) begin
          hold_d = hold_q - HW'(1);
        end else begin
          state_d = seq_run;
        end
      end
      seq_run: begin
        if (pin_reset) begin
          state_d = seq_hold;
          hold_d = HOLD_LOAD;
          kind_d = kind_pin_run;
        end else if (watchdog_timer_expire) begin
          state_d = seq_hold;
          hold_d = HOLD_LOAD;
          kind_d = kind_watchdog_run;
          expired_d = 1'b1;
        end else if (sleep_enter) begin
          state_d = seq_sleep;
          expired_d = 1'b0;
          asleep_d = 1'b1;
        end else if (clear_watchdog) begin
          expired_d = 1'b0;
          asleep_d = 1'b0;
        end
      end
      seq_sleep: begin
        if (pin_reset) begin
          state_d = seq_hold;
          hold_d = HOLD_LOAD;
          kind_d = kind_pin_sleep;
          expired_d = 1'b0;
          asleep_d = 1'b1;
        end else if (watchdog_timer_expire) begin
          state_d = seq_run;
          kind_d = kind_watchdog_wake;
          expired_d = 1'b1;
          asleep_d = 1'b1;
          wake_d = 1'b1;
        end else if (interrupt_wake) begin
          state_d = seq_run;
          kind_d = kind_interrupt_wake;
          expired_d = 1'b0;
          asleep_d = 1'b1;
          wake_d = 1'b1;
        end
      end
    endcase
  end

  // Power-on starts in hold with both flags reading one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= seq_hold;
      hold_q <= HOLD_LOAD;
      kind_q <= kind_power_on;
      expired_q <= 1'b0;
      asleep_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      kind_q <= kind_d;
      expired_q <= expired_d;
      asleep_q <= asleep_d;
      wake_q <= wake_d;
    end
  end

  // Flags stored inverted so reset needs a zero constant
  assign watchdog_expired_flag = !expired_q ? 1'b1 : 1'b0;
  assign sleep_flag = !asleep_q ? 1'b1 : 1'b0;
  assign core_reset = (state_q == seq_hold);
  assign wake_pulse = wake_q;
  assign reset_kind = kind_q;

  // Storage with no reset at all; power-on leaves it undefined
  logic [RETAIN_W-1:0] retained_q;
  always_ff @(posedge clk) begin
    if (retained_wr_en) begin
      retained_q <= retained_wr_data;
    end
  end
  assign retained_rd_data = retained_q;
endmodule

// ---- osc_trim_regs.svh ----
// Constants for oscillator trim, clock output and reset-kind logic
`ifndef OSC_TRIM_REGS_SVH
`define OSC_TRIM_REGS_SVH

// Oscillator select codes
`define SEL_EXTERNAL_RC_MODE_DIVIDED_CLOCK_OUT 3'h7
`define SEL_EXTERNAL_RC_MODE_IO 3'h6
`define SEL_INTERNAL_RC_MODE_DIVIDED_CLOCK_OUT 3'h5
`define SEL_INTERNAL_RC_MODE_IO 3'h4
`define SEL_INVALID 3'h3
`define SEL_HS 3'h2
`define SEL_XT 3'h1
`define SEL_LP 3'h0
`define SEL_RESET 3'h4

// Trim register layout
`define TRIM_FINE_MSB 7
`define TRIM_FINE_LSB 4
`define TRIM_FAST_BIT 3
`define TRIM_SLOW_BIT 2
`define TRIM_IMPL_MASK 8'hFC
`define TRIM_RESET 8'h80

// Internal oscillator phase model, 16-bit accumulator at system clock
`define NCO_BASE 16'h127B
`define NCO_FINE_STEP 16'h0040
`define NCO_COARSE_STEP 16'h0200

// Timing
`define CLK_PERIOD_NS 20
`define PIN_FILTER_NS 200
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_CYCLES 4
`define DIVIDED_CLOCK_OUT_DIVIDE 4

`endif

// ---- osc_trim_pkg.sv ----
// Types and decode helpers for oscillator and reset-kind logic
`include "osc_trim_regs.svh"

package osc_trim_pkg;

  typedef enum logic [2:0] {
    crystal_low_power,
    crystal_standard,
    crystal_high_speed,
    mode_invalid,
    internal_rc_mode,
    internal_rc_divided_clock_out,
    external_rc_mode,
    external_rc_divided_clock_out
  } osc_mode_e;

  typedef enum logic [2:0] {
    kind_power_on,
    kind_pin_run,
    kind_pin_sleep,
    kind_watchdog_run,
    kind_watchdog_wake,
    kind_interrupt_wake
  } reset_kind_e;

  typedef enum logic [1:0] {
    seq_hold,
    seq_run,
    seq_sleep
  } seq_state_e;

  function automatic osc_mode_e decode_mode(input logic [2:0] sel);
    osc_mode_e m;
    m = mode_invalid;
    unique case (sel)
      `SEL_EXTERNAL_RC_MODE_DIVIDED_CLOCK_OUT: m = external_rc_divided_clock_out;
      `SEL_EXTERNAL_RC_MODE_IO: m = external_rc_mode;
      `SEL_INTERNAL_RC_MODE_DIVIDED_CLOCK_OUT: m = internal_rc_divided_clock_out;
      `SEL_INTERNAL_RC_MODE_IO: m = internal_rc_mode;
      `SEL_INVALID: m = mode_invalid;
      `SEL_HS: m = crystal_high_speed;
      `SEL_XT: m = crystal_standard;
      `SEL_LP: m = crystal_low_power;
    endcase
    return m;
  endfunction

  function automatic logic is_internal(input osc_mode_e m);
    return (m == internal_rc_mode) || (m == internal_rc_divided_clock_out);
  endfunction

  function automatic logic has_divided_clock_out(input osc_mode_e m);
    return (m == internal_rc_divided_clock_out) || (m == external_rc_divided_clock_out);
  endfunction

endpackage

// ---- reset_pin_filter.sv ----
// Synchroniser and pulse filter for the external reset pin
`timescale 1ns/1ps
`include "osc_trim_regs.svh"

module reset_pin_filter #(
  parameter int FILTER_CYCLES = `PIN_FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_n,
  output logic asserted
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(FILTER_CYCLES);

  logic s1_q, s2_q, s3_q, level_q;
  logic [CW-1:0] cnt_q;
  logic asserted_q;

  // Three-stage sampler; level moves only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) level_q <= s3_q;
    end
  end

  // Low level must persist LIMIT + 1 cycles; shorter dips are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      asserted_q <= 1'b0;
    end else if (level_q) begin
      cnt_q <= '0;
      asserted_q <= 1'b0;
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + CW'(1);
    end else begin
      asserted_q <= 1'b1;
    end
  end

  assign asserted = asserted_q;
endmodule

// ---- osc_trim_divided_clock_out_reset_kinds_monitor.sv ----
// Port checker for trim, clock output and reset-kind behaviour
`timescale 1ns/1ps
module osc_trim_divided_clock_out_reset_kinds_monitor #(
  parameter int FILTER_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input osc_trim_pkg::osc_mode_e osc_mode,
  input osc_trim_pkg::reset_kind_e reset_kind,
  input wire logic osc_out_pin_o,
  input wire logic osc_out_pin_oe,
  input wire logic osc_tick,
  input wire logic external_reset_pin_n,
  input wire logic external_reset_pin_oe,
  input wire logic trim_wr_en,
  input wire logic [7:0] trim_wr_data,
  input wire logic [7:0] trim_rd_data,
  input wire logic watchdog_timer_expire,
  input wire logic core_reset,
  input wire logic watchdog_expired_flag,
  input wire logic config_invalid
);
  import osc_trim_pkg::*;
  localparam int MIN_LOW = FILTER_CYCLES + 1;
  logic [3:0] tk_q;
  logic [7:0] low_q;
  logic arm_q;
  logic prv_q;
  wire chg = osc_out_pin_o != prv_q;
  // Ticks between output edges; first edge after a stop only arms
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tk_q <= 4'h0;
      arm_q <= 1'b0;
    end else if (core_reset || !osc_out_pin_oe) begin
      tk_q <= 4'h0;
      arm_q <= 1'b0;
    end else if (chg) begin
      tk_q <= {3'h0, osc_tick};
      arm_q <= 1'b1;
    end else begin
      tk_q <= tk_q + {3'h0, osc_tick};
    end
  end
  // Output history and length of the current low on the reset pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prv_q <= 1'b0;
      low_q <= 8'h00;
    end else begin
      prv_q <= osc_out_pin_o;
      if (external_reset_pin_n) low_q <= 8'h00;
      else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Count fixed at the default hold of four plus one
  sequence hold_run;
    core_reset [*5] ##1 !core_reset;
  endsequence
  a_pin_not_driven: assert property (!external_reset_pin_oe)
    else $error("reset pin driven");
  a_divided_clock_out_gate: assert property (osc_out_pin_oe ==
    (osc_mode == internal_rc_divided_clock_out || osc_mode == external_rc_divided_clock_out))
    else $error("clock out enable wrong for mode");
  a_out_quiet: assert property (!osc_out_pin_oe |-> !osc_out_pin_o)
    else $error("clock out level while not enabled");
  a_invalid_code: assert property (config_invalid == (osc_mode == mode_invalid))
    else $error("invalid flag wrong");
  a_trim_write: assert property (trim_wr_en && !core_reset |=>
    trim_rd_data == ($past(trim_wr_data) & 8'hFC))
    else $error("trim write not taken");
  a_wdt_flag: assert property (watchdog_timer_expire && !core_reset &&
    external_reset_pin_n |=> !watchdog_expired_flag)
    else $error("expired flag not cleared");
  a_wdt_hold: assert property ($rose(core_reset) &&
    reset_kind == kind_watchdog_run |-> hold_run)
    else $error("watchdog hold length wrong");
  a_div_four: assert property (arm_q && chg |-> tk_q == 4'h2)
    else $error("clock out not divided by four");
  a_pin_filter: assert property ($rose(core_reset) && (reset_kind == kind_pin_run ||
    reset_kind == kind_pin_sleep) |-> low_q >= MIN_LOW)
    else $error("short pin low taken as reset");
endmodule
bind osc_trim_divided_clock_out_reset_kinds osc_trim_divided_clock_out_reset_kinds_monitor #(
  .FILTER_CYCLES(FILTER_CYCLES)
) mon (.clk, .rst_n, .osc_mode, .reset_kind, .osc_out_pin_o, .osc_out_pin_oe,
  .osc_tick, .external_reset_pin_n, .external_reset_pin_oe, .trim_wr_en, .trim_wr_data,
  .trim_rd_data, .watchdog_timer_expire, .core_reset, .watchdog_expired_flag,
  .config_invalid);

// ---- osc_source_model.sv ----
// External clock source at the oscillator input pin
`timescale 1ns/1ps
module osc_source_model #(
  parameter int HALF_NS = 110
) (
  input wire logic run,
  output logic osc_in_pin
);
  // Toggles only while run is high; a 1 ns lead keeps its edges off the system clock edges
  initial begin
    osc_in_pin = 1'b0;
    #1;
    forever begin
      #(HALF_NS);
      if (run) osc_in_pin = !osc_in_pin;
    end
  end
endmodule

// ---- osc_trim_divided_clock_out_reset_kinds_tb.sv ----
// Self-checking bench for trim, clock output and reset kinds
`timescale 1ns/1ps
`define CHK(n, g, e) check(n, 16'(g), 16'(e));
module osc_trim_divided_clock_out_reset_kinds_tb;
  import osc_trim_pkg::*;
  logic clk, rst_n, run, osc_in_pin, osc_out_pin_o, osc_out_pin_oe, osc_tick;
  logic external_reset_pin_n, external_reset_pin_o, external_reset_pin_oe;
  logic trim_wr_en, retained_wr_en, watchdog_timer_expire, sleep_enter;
  logic clear_watchdog, interrupt_wake, config_invalid, core_reset, wake_pulse;
  logic watchdog_expired_flag, sleep_flag, hit;
  logic [2:0] osc_select;
  logic [7:0] trim_wr_data, trim_rd_data, retained_wr_data, retained_rd_data;
  logic [7:0] codes [4] = '{8'h00, 8'hF0, 8'hF8, 8'hF4};
  osc_mode_e osc_mode;
  reset_kind_e reset_kind;
  int mismatches, compares, cyc, ticks, tog;
  int tt [4];
  // Factory trim copy held by the bench, safe from any erase
  localparam logic [7:0] cal_value = 8'h34;
  osc_trim_divided_clock_out_reset_kinds uut (.clk, .rst_n, .osc_select, .osc_in_pin,
    .osc_out_pin_o, .osc_out_pin_oe, .external_reset_pin_n, .external_reset_pin_o,
    .external_reset_pin_oe, .trim_wr_en, .trim_wr_data, .trim_rd_data, .retained_wr_en,
    .retained_wr_data, .retained_rd_data, .watchdog_timer_expire, .sleep_enter,
    .clear_watchdog, .interrupt_wake, .osc_tick, .osc_mode, .config_invalid,
    .core_reset, .wake_pulse, .reset_kind, .watchdog_expired_flag, .sleep_flag);
  osc_source_model src (.run, .osc_in_pin);
  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim;
    end
  end
  task automatic check(string n, logic [15:0] g, logic [15:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // Lets a pending reset start, then waits for it to end
  task automatic settle;
    tick(2);
    for (int i = 0; i < 60 && core_reset !== 1'h0; i++) tick(1);
  endtask
  task automatic por(logic [2:0] s);
    @(negedge clk);
    rst_n = 1'h0;
    osc_select = s;
    tick(3);
    rst_n = 1'h1;
    settle;
  endtask
  task automatic pulse(int k);
    @(negedge clk);
    case (k)
      0: watchdog_timer_expire = 1'h1;
      1: sleep_enter = 1'h1;
      2: clear_watchdog = 1'h1;
      default: interrupt_wake = 1'h1;
    endcase
    @(negedge clk);
    {watchdog_timer_expire, sleep_enter, clear_watchdog, interrupt_wake} = 4'h0;
  endtask
  task automatic wr(logic [7:0] d, logic ret);
    @(negedge clk);
    trim_wr_en = !ret;
    retained_wr_en = ret;
    trim_wr_data = d;
    retained_wr_data = d;
    @(negedge clk);
    trim_wr_en = 1'h0;
    retained_wr_en = 1'h0;
  endtask
  task automatic pin(int n);
    @(negedge clk);
    external_reset_pin_n = 1'h0;
    tick(n);
    external_reset_pin_n = 1'h1;
  endtask
  task automatic flags(logic e, logic s);
    `CHK("expired", watchdog_expired_flag, e)
    `CHK("sleep", sleep_flag, s)
  endtask
  task automatic count(int n);
    logic p;
    ticks = 0;
    tog = 0;
    p = osc_out_pin_o;
    repeat (n) begin
      @(negedge clk);
      if (osc_tick === 1'h1) ticks++;
      if (osc_out_pin_o !== p) tog++;
      p = osc_out_pin_o;
    end
  endtask
  // Main sequence
  initial begin
    {rst_n, run, trim_wr_en, retained_wr_en, watchdog_timer_expire} = 5'h0;
    {sleep_enter, clear_watchdog, interrupt_wake} = 3'h0;
    external_reset_pin_n = 1'h1;
    osc_select = 3'h4;
    trim_wr_data = 8'h00;
    retained_wr_data = 8'h00;
    tick(3);
    rst_n = 1'h1;
    settle;
    `CHK("kind", reset_kind, kind_power_on)
    flags(1'h1, 1'h1);
    `CHK("trim", trim_rd_data, 8'h80)
    wr(8'hA4, 1'h0);
    `CHK("trim", trim_rd_data, 8'hA4)
    wr(8'hFC, 1'h0);
    `CHK("trim", trim_rd_data, 8'hFC)
    $display("test power-on and trim done");
    wr(8'h5A, 1'h1);
    pulse(0);
    settle;
    `CHK("kind", reset_kind, kind_watchdog_run)
    flags(1'h0, 1'h1);
    `CHK("trim", trim_rd_data, 8'h80)
    `CHK("retained", retained_rd_data, 8'h5A)
    `CHK("pin_oe", external_reset_pin_oe, 1'h0)
    `CHK("pin_o", external_reset_pin_o, 1'h0)
    pulse(2);
    flags(1'h1, 1'h1);
    wr(cal_value, 1'h0);
    pulse(1);
    flags(1'h1, 1'h0);
    pulse(0);
    `CHK("wake", wake_pulse, 1'h1)
    tick(1);
    `CHK("wake_end", wake_pulse, 1'h0)
    `CHK("kind", reset_kind, kind_watchdog_wake)
    flags(1'h0, 1'h0);
    `CHK("trim", trim_rd_data, 8'h34)
    `CHK("core_reset", core_reset, 1'h0)
    pulse(1);
    pulse(3);
    `CHK("wake", wake_pulse, 1'h1)
    tick(1);
    `CHK("kind", reset_kind, kind_interrupt_wake)
    flags(1'h1, 1'h0);
    $display("test watchdog and sleep done");
    hit = 1'h0;
    pin(5);
    repeat (20) begin
      tick(1);
      hit = hit | core_reset;
    end
    `CHK("short_pin", hit, 1'h0)
    pin(30);
    settle;
    `CHK("kind", reset_kind, kind_pin_run)
    flags(1'h1, 1'h0);
    `CHK("retained", retained_rd_data, 8'h5A)
    pulse(2);
    pulse(1);
    pin(30);
    settle;
    `CHK("kind", reset_kind, kind_pin_sleep)
    flags(1'h1, 1'h0);
    $display("test reset pin done");
    for (int i = 0; i < 8; i++) begin
      por(3'(i));
      `CHK("mode", osc_mode, osc_mode_e'(i))
      `CHK("invalid", config_invalid, i == 3)
      `CHK("divided_clock_out_oe", osc_out_pin_oe, i == 5 || i == 7)
    end
    $display("test mode decode done");
    por(3'h1);
    run = 1'h1;
    count(1024);
    run = 1'h0;
    `CHK("ext_ticks", ticks >= 91 && ticks <= 95, 1'h1)
    $display("test external clock done");
    por(3'h5);
    for (int j = 0; j < 4; j++) begin
      wr(codes[j], 1'h0);
      count(1024);
      tt[j] = ticks;
      `CHK("divide", 2 * tog >= ticks - 3 && 2 * tog <= ticks + 3, 1'h1)
    end
    `CHK("fine_up", tt[1] > tt[0], 1'h1)
    `CHK("coarse_up", tt[2] > tt[1], 1'h1)
    `CHK("coarse_down", tt[3] < tt[1], 1'h1)
    $display("test internal trim done");
    end_sim;
  end
endmodule
